//--- hdl/igr_pkg.sv
// shared constants, register map and bus carriers of the input gain-ranging control
package igr_pkg;

  localparam int          SAMPLE_W       = 14;
  localparam int          MAG_W          = 14;
  localparam int          THR_W          = 10;
  localparam int          DWELL_W        = 20;
  localparam int          RELIN_W        = 6;
  localparam int          CODE_W         = 3;
  localparam int          ADR_W          = 8;

  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_UPPER      = 8'h04;
  localparam logic [7:0]  OFS_LOWER      = 8'h08;
  localparam logic [7:0]  OFS_DWELL      = 8'h0c;
  localparam logic [7:0]  OFS_STATUS     = 8'h10;

  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_DLY_LSB   = 8;
  localparam int          ST_CODE_LSB    = 0;
  localparam int          ST_RELIN_LSB   = 4;
  localparam int          ST_BUSY_BIT    = 8;
  localparam int          ST_DWELL_BIT   = 9;

  localparam logic [THR_W-1:0]   UPPER_RST = 10'h3ff;
  localparam logic [THR_W-1:0]   LOWER_RST = 10'h000;
  localparam logic [DWELL_W-1:0] DWELL_RST = 20'h00001;
  localparam logic [RELIN_W-1:0] DLY_RST   = 6'h00;
  localparam logic [CODE_W-1:0]  CODE_MIN  = 3'h0;
  localparam logic [CODE_W-1:0]  CODE_MAX  = 3'h7;

  typedef enum logic [1:0] {
    IGR_OFF     = 2'b00,
    IGR_COMPARE = 2'b01,
    IGR_DWELL   = 2'b10
  } igr_state_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } igr_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } igr_wb_rsp_t;

endpackage

//--- hdl/igr_gain_ctrl.sv
// input gain-ranging control with classic wishbone register slave
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ns

// Notes on behaviour
// - the block produces a three-bit gain code.
// - with gain control enabled, the three code pins are driven as outputs carrying the code.
// - a sample magnitude above the upper threshold lowers the code by one step.
// - a lowering takes effect at once, with no dwell wait, to avoid converter overflow.
// - a sample magnitude below the lower threshold raises the code by one, only after the dwell.
// - falling below the lower threshold loads the dwell countdown from the 20-bit dwell setting.
// - the countdown drops by one each clock while samples stay below the lower threshold.
// - when the countdown reaches one the code is raised by one step.
// - a sample at or above the lower threshold abandons the pending raise and resumes comparing.
// - 10-bit thresholds are compared with the top 10 bits of the absolute sample magnitude.
// - the code reaches relinearization after a programmable 6-bit delay of up to 63 clocks.
// - new adjustments requested while an earlier relinearization delay runs are ignored.
// - enabling gain control forces the code to zero, minimum external gain, first.
module igr_gain_ctrl
  import igr_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire igr_pkg::igr_wb_req_t  wb_req,
  output igr_pkg::igr_wb_rsp_t       wb_rsp,
  input  wire logic [igr_pkg::SAMPLE_W-1:0] sample,
  output logic [igr_pkg::CODE_W-1:0] gain_step_code,
  output logic                       gain_step_code_oe,
  output logic [igr_pkg::CODE_W-1:0] relin_code
);
  import igr_pkg::*;

  // byte-lane merge shared by every writable register
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
                                              input logic [31:0] wr_val,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wr_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // saturating one-step move of the gain code
  function automatic logic [CODE_W-1:0] step_code(input logic [CODE_W-1:0] code,
                                                  input logic              up);
    logic [CODE_W-1:0] res;
    res = code;
    if (up) begin
      if (code != CODE_MAX) begin
        res = code + 3'h1;
      end
    end else begin
      if (code != CODE_MIN) begin
        res = code - 3'h1;
      end
    end
    return res;
  endfunction

  // ---------------- register file ----------------
  logic                 gc_enable;
  logic [RELIN_W-1:0]   relin_delay;
  logic [THR_W-1:0]     upper_thr;
  logic [THR_W-1:0]     lower_thr;
  logic [DWELL_W-1:0]   dwell_time;
  logic                 ack;
  logic [31:0]          rd_data;

  logic                 next_gc_enable;
  logic [RELIN_W-1:0]   next_relin_delay;
  logic [THR_W-1:0]     next_upper_thr;
  logic [THR_W-1:0]     next_lower_thr;
  logic [DWELL_W-1:0]   next_dwell_time;
  logic                 next_ack;
  logic [31:0]          next_rd_data;

  // gain path state
  igr_state_t           state;
  logic [DWELL_W-1:0]   dwell_cnt;
  logic [CODE_W-1:0]    code;
  logic [RELIN_W-1:0]   relin_cnt;
  logic [CODE_W-1:0]    relin_pend;
  logic [CODE_W-1:0]    relin_out;

  logic                 req;
  logic [31:0]          ctrl_word;
  logic [31:0]          upper_word;
  logic [31:0]          lower_word;
  logic [31:0]          dwell_word;
  logic [31:0]          status_word;
  logic [31:0]          wr_ctrl;
  logic [31:0]          wr_upper;
  logic [31:0]          wr_lower;
  logic [31:0]          wr_dwell;

  assign req = wb_req.cyc && wb_req.stb && !ack;

  always_comb begin
    ctrl_word                              = 32'h0;
    ctrl_word[CTRL_EN_BIT]                 = gc_enable;
    ctrl_word[CTRL_DLY_LSB +: RELIN_W]     = relin_delay;
    upper_word                             = {22'h0, upper_thr};
    lower_word                             = {22'h0, lower_thr};
    dwell_word                             = {12'h0, dwell_time};
    status_word                            = 32'h0;
    status_word[ST_CODE_LSB +: CODE_W]     = code;
    status_word[ST_RELIN_LSB +: CODE_W]    = relin_out;
    status_word[ST_BUSY_BIT]               = (relin_cnt != 6'h00);
    status_word[ST_DWELL_BIT]              = (state == IGR_DWELL);
    wr_ctrl  = merge_lanes(ctrl_word, wb_req.dat, wb_req.sel);
    wr_upper = merge_lanes(upper_word, wb_req.dat, wb_req.sel);
    wr_lower = merge_lanes(lower_word, wb_req.dat, wb_req.sel);
    wr_dwell = merge_lanes(dwell_word, wb_req.dat, wb_req.sel);
  end

  always_comb begin
    next_gc_enable   = gc_enable;
    next_relin_delay = relin_delay;
    next_upper_thr   = upper_thr;
    next_lower_thr   = lower_thr;
    next_dwell_time  = dwell_time;
    next_ack         = req;
    next_rd_data     = 32'h0;
    if (req && wb_req.we) begin
      case (wb_req.adr)
        OFS_CTRL: begin
          next_gc_enable   = wr_ctrl[CTRL_EN_BIT];
          next_relin_delay = wr_ctrl[CTRL_DLY_LSB +: RELIN_W];
        end
        OFS_UPPER: next_upper_thr  = wr_upper[THR_W-1:0];
        OFS_LOWER: next_lower_thr  = wr_lower[THR_W-1:0];
        OFS_DWELL: next_dwell_time = wr_dwell[DWELL_W-1:0];
        default: begin
        end
      endcase
    end else if (req) begin
      // unmapped addresses still acknowledge and read as zero
      case (wb_req.adr)
        OFS_CTRL:   next_rd_data = ctrl_word;
        OFS_UPPER:  next_rd_data = upper_word;
        OFS_LOWER:  next_rd_data = lower_word;
        OFS_DWELL:  next_rd_data = dwell_word;
        OFS_STATUS: next_rd_data = status_word;
        default:    next_rd_data = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gc_enable   <= 1'b0;
      relin_delay <= DLY_RST;
      upper_thr   <= UPPER_RST;
      lower_thr   <= LOWER_RST;
      dwell_time  <= DWELL_RST;
      ack         <= 1'b0;
      rd_data     <= 32'h0;
    end else begin
      gc_enable   <= next_gc_enable;
      relin_delay <= next_relin_delay;
      upper_thr   <= next_upper_thr;
      lower_thr   <= next_lower_thr;
      dwell_time  <= next_dwell_time;
      ack         <= next_ack;
      rd_data     <= next_rd_data;
    end
  end

  assign wb_rsp.ack = ack;
  assign wb_rsp.dat = rd_data;

  // ---------------- gain path ----------------
  logic [MAG_W-1:0]     mag;
  logic [THR_W-1:0]     mag_top;
  logic                 over_upper;
  logic                 under_lower;
  logic                 busy;

  igr_state_t           next_state;
  logic [DWELL_W-1:0]   next_dwell_cnt;
  logic [CODE_W-1:0]    next_code;
  logic [RELIN_W-1:0]   next_relin_cnt;
  logic [CODE_W-1:0]    next_relin_pend;
  logic [CODE_W-1:0]    next_relin_out;
  logic                 adjust;
  logic [CODE_W-1:0]    adj_code;

  always_comb begin
    // the most negative sample maps to 2^13, which still fits the unsigned magnitude
    if (sample[SAMPLE_W-1]) begin
      mag = MAG_W'(-sample);
    end else begin
      mag = MAG_W'(sample);
    end
  end

  assign mag_top     = mag[MAG_W-1 -: THR_W];
  assign over_upper  = mag_top > upper_thr;
  assign under_lower = mag_top < lower_thr;
  assign busy        = (relin_cnt != 6'h00);

  always_comb begin
    next_state      = state;
    next_dwell_cnt  = dwell_cnt;
    next_code       = code;
    next_relin_cnt  = relin_cnt;
    next_relin_pend = relin_pend;
    next_relin_out  = relin_out;
    adjust          = 1'b0;
    adj_code        = code;
    case (state)
      IGR_OFF: begin
        next_code      = CODE_MIN;
        next_dwell_cnt = '0;
        next_relin_cnt = '0;
        next_relin_out = CODE_MIN;
        if (gc_enable) begin
          next_state = IGR_COMPARE;
        end
      end
      IGR_COMPARE: begin
        if (over_upper) begin
          adjust   = 1'b1;
          adj_code = step_code(code, 1'b0);
        end else if (under_lower) begin
          next_state     = IGR_DWELL;
          next_dwell_cnt = dwell_time;
        end
      end
      IGR_DWELL: begin
        if (over_upper) begin
          next_state = IGR_COMPARE;
          adjust     = 1'b1;
          adj_code   = step_code(code, 1'b0);
        end else if (!under_lower) begin
          next_state = IGR_COMPARE;
        end else if (dwell_cnt <= 20'h00001) begin
          // a zero dwell setting behaves as one so the timer cannot wrap
          next_state = IGR_COMPARE;
          adjust     = 1'b1;
          adj_code   = step_code(code, 1'b1);
        end else begin
          next_dwell_cnt = dwell_cnt - 20'h00001;
        end
      end
      default: begin
        next_state = IGR_OFF;
      end
    endcase

    if (state != IGR_OFF) begin
      if (busy) begin
        next_relin_cnt = relin_cnt - 6'h01;
        if (relin_cnt == 6'h01) begin
          next_relin_out = relin_pend;
        end
      end
      // a request during a running relinearization delay is dropped
      if (adjust && !busy && adj_code != code) begin
        next_code = adj_code;
        if (relin_delay == 6'h00) begin
          next_relin_out = adj_code;
        end else begin
          next_relin_cnt  = relin_delay;
          next_relin_pend = adj_code;
        end
      end
    end

    // a relinearization delay still running at disable must not land a stale code later
    if (!gc_enable) begin
      next_state     = IGR_OFF;
      next_code      = CODE_MIN;
      next_relin_cnt = '0;
      next_relin_out = CODE_MIN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state      <= IGR_OFF;
      dwell_cnt  <= '0;
      code       <= CODE_MIN;
      relin_cnt  <= '0;
      relin_pend <= CODE_MIN;
      relin_out  <= CODE_MIN;
    end else begin
      state      <= next_state;
      dwell_cnt  <= next_dwell_cnt;
      code       <= next_code;
      relin_cnt  <= next_relin_cnt;
      relin_pend <= next_relin_pend;
      relin_out  <= next_relin_out;
    end
  end

  assign gain_step_code    = code;
  assign gain_step_code_oe = gc_enable;
  assign relin_code        = relin_out;

endmodule

//--- bench/igr_amp_model.sv
// behavioural external gain-ranging amplifier ahead of the converter
`timescale 1ns/1ns
module igr_amp_model #(
  parameter int SETTLE = 2
) (
  input  wire logic                                ref_clk,
  input  wire logic [igr_pkg::CODE_W-1:0]          gain_step_code,
  input  wire logic                                gain_step_code_oe,
  input  wire logic signed [igr_pkg::SAMPLE_W-1:0] level,
  output logic [igr_pkg::SAMPLE_W-1:0]             sample
);
  logic [2:0]         gain_q [SETTLE+1];
  logic signed [31:0] boosted;
  // released pins sit low, so an idle code means minimum gain
  always_ff @(posedge ref_clk) begin
    gain_q[0] <= gain_step_code_oe ? gain_step_code : 3'h0;
    for (int i = 1; i <= SETTLE; i++) begin
      gain_q[i] <= gain_q[i-1];
    end
  end
  // 6 dB a step; the converter clips at full scale
  always_comb begin
    boosted = 32'(level) <<< gain_q[SETTLE];
    if (boosted > 32'sd8191) sample = 14'h1fff;
    else if (boosted < -32'sd8192) sample = 14'h2000;
    else sample = boosted[13:0];
  end
endmodule

//--- bench/igr_gain_ctrl_asserts.sv
// port-level checks of the gain-ranging control
`timescale 1ns/1ns
module igr_gain_ctrl_asserts
  import igr_pkg::*;
(
  input wire logic                          ref_clk,
  input wire logic                          reset,
  input wire igr_pkg::igr_wb_req_t          wb_req,
  input wire igr_pkg::igr_wb_rsp_t          wb_rsp,
  input wire logic [igr_pkg::SAMPLE_W-1:0]  sample,
  input wire logic [igr_pkg::CODE_W-1:0]    gain_step_code,
  input wire logic                          gain_step_code_oe,
  input wire logic [igr_pkg::CODE_W-1:0]    relin_code
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire logic req = wb_req.cyc && wb_req.stb;
  wire logic [3:0] cw = {1'b0, gain_step_code};

  AST_ACK_NEXT: assert property (req && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("ack late");
  AST_ACK_ONCE: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property (wb_rsp.ack |-> $past(req))
    else $error("ack without request");
  AST_OFF_ZERO: assert property (
    !gain_step_code_oe && !$past(gain_step_code_oe) |-> gain_step_code == 3'h0 && relin_code == 3'h0)
    else $error("code moves while off");
  AST_EN_ZERO: assert property ($rose(gain_step_code_oe) |-> gain_step_code == CODE_MIN)
    else $error("enable not at zero");
  AST_ONE_STEP: assert property (
    gain_step_code_oe && $past(gain_step_code_oe) |-> $stable(gain_step_code)
      || cw == $past(cw) + 4'h1 || cw + 4'h1 == $past(cw))
    else $error("code jump");
  AST_RELIN_MATCH: assert property (
    gain_step_code_oe && $changed(relin_code) |-> relin_code == gain_step_code)
    else $error("relin code stale");
  AST_STATUS_CODE: assert property (
    wb_rsp.ack && !$past(wb_req.we) && $past(wb_req.adr) == OFS_STATUS
      |-> wb_rsp.dat[2:0] == $past(gain_step_code))
    else $error("status code wrong");
endmodule

bind igr_gain_ctrl igr_gain_ctrl_asserts chk_u (.ref_clk(ref_clk), .reset(reset),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .sample(sample), .gain_step_code(gain_step_code),
  .gain_step_code_oe(gain_step_code_oe), .relin_code(relin_code));

//--- bench/tb_igr_gain_ctrl.sv
// self-checking bench for the gain-ranging control
`timescale 1ns/1ns
module tb_igr_gain_ctrl;
  import igr_pkg::*;
  logic                       ref_clk = 1'b0;
  logic                       reset = 1'b1;
  igr_wb_req_t                wb_req = '0;
  igr_wb_rsp_t                wb_rsp;
  logic [SAMPLE_W-1:0]        sample;
  logic [CODE_W-1:0]          code;
  logic [CODE_W-1:0]          relin;
  logic                       oe;
  logic signed [SAMPLE_W-1:0] level = '0;
  logic [31:0]                rd;
  int                         fail_count = 0;
  int                         checks = 0;

  always #5 ref_clk = ~ref_clk;

  igr_gain_ctrl dut_u (.ref_clk(ref_clk), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .sample(sample), .gain_step_code(code), .gain_step_code_oe(oe), .relin_code(relin));
  igr_amp_model #(.SETTLE(2)) amp_u (.ref_clk(ref_clk), .gain_step_code(code),
    .gain_step_code_oe(oe), .level(level), .sample(sample));

  task automatic final_report();
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp_v, input logic [31:0] got);
    checks++;
    if (got !== exp_v) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp_v, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    int n;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      final_report();
    end
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf, rd);
  endtask

  // a stuck code must end the run, not stall it
  task automatic wait_code(input logic [2:0] v, input int lim);
    int n;
    n = 0;
    while (code !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk("code", 32'(v), 32'(code));
    if (n >= lim) final_report();
  endtask

  task automatic t_regs();
    logic [7:0]  a [5] = '{OFS_CTRL, OFS_UPPER, OFS_LOWER, OFS_DWELL, 8'h14};
    logic [31:0] e [5] = '{32'h0, 32'(UPPER_RST), 32'(LOWER_RST), 32'(DWELL_RST), 32'h0};
    chk("oe", 0, 32'(oe));
    chk("code", 0, 32'(code));
    wr(8'h14, 32'h5a);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, a[i], 32'h0, 4'hf, rd);
      chk("reg", e[i], rd);
    end
  endtask

  task automatic t_dwell();
    wr(OFS_LOWER, 32'h10);
    wr(OFS_UPPER, 32'h100);
    wr(OFS_DWELL, 32'h8);
    level <= 14'sh200;
    wr(OFS_CTRL, 32'h1);
    chk("oe", 1, 32'(oe));
    chk("code", 0, 32'(code));
    level <= 14'sh1;
    cyc(4);
    level <= 14'sh200;
    cyc(20);
    chk("code", 0, 32'(code));
    level <= 14'sh1;
    cyc(8);
    chk("code", 0, 32'(code));
    wait_code(3'h1, 4);
    wait_code(3'h7, 80);
    cyc(30);
    chk("code", 7, 32'(code));
    bus(1'b0, OFS_STATUS, 32'h0, 4'hf, rd);
    chk("status", 32'h77, 32'(rd[6:0]));
  endtask

  task automatic t_overload();
    level <= 14'sh1fff;
    cyc(2);
    chk("code", 6, 32'(code));
    cyc(1);
    chk("code", 5, 32'(code));
    chk("relin", 5, 32'(relin));
    wait_code(3'h0, 10);
    cyc(10);
    chk("code", 0, 32'(code));
  endtask

  task automatic t_relin();
    wr(OFS_CTRL, 32'h501);
    level <= 14'sh1;
    wait_code(3'h2, 60);
    cyc(6);
    level <= 14'sh1fff;
    for (int n = 0; n < 4 && code === 3'h2; n++) cyc(1);
    chk("code", 1, 32'(code));
    cyc(3);
    chk("code", 1, 32'(code));
    chk("relin", 2, 32'(relin));
    cyc(2);
    chk("relin", 1, 32'(relin));
  endtask

  task automatic t_disable();
    wr(OFS_CTRL, 32'h0);
    cyc(1);
    chk("oe", 0, 32'(oe));
    chk("code", 0, 32'(code));
    chk("relin", 0, 32'(relin));
    level <= 14'sh1;
    cyc(30);
    chk("code", 0, 32'(code));
    bus(1'b1, OFS_UPPER, 32'h2ff, 4'h1, rd);
    bus(1'b0, OFS_UPPER, 32'h0, 4'hf, rd);
    chk("upper", 32'h1ff, rd);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_dwell();
    t_overload();
    t_relin();
    t_disable();
    final_report();
  end
endmodule
